// >>> pin_source.sv
// pulse source that drives the external count/gate pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // command
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  input  wire logic [7:0] hi_len,
  input  wire logic [7:0] lo_len,
  // pin side
  output logic            pin,
  output logic            busy
);
  logic [7:0] left_reg;
  logic [7:0] run_reg;

  // the bench keeps both lengths at five cycles or more; a gate is held for tens of cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
      busy <= 1'b0;
      left_reg <= 8'h00;
      run_reg <= 8'h00;
    end else if (!busy) begin
      if (go && pulses != 8'h00) begin
        busy <= 1'b1;
        pin <= 1'b1;
        left_reg <= pulses;
        run_reg <= hi_len;
      end
    end else if (run_reg > 8'h01) begin
      run_reg <= run_reg - 8'h01;
    end else if (pin) begin
      pin <= 1'b0;
      run_reg <= lo_len;
      left_reg <= left_reg - 8'h01;
    end else if (left_reg != 8'h00) begin
      pin <= 1'b1;
      run_reg <= hi_len;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        match_irq;
  logic        irq;
  logic        go;
  logic [7:0]  pulses;
  logic [7:0]  hi_len;
  logic        busy;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        err;
  int          fails;
  int          total_checks;
  int          cycles;
  int          p;
  int          m;

  // short prescale taps keep the run brief
  timer_counter_two_modes #(.TICK0_CYCLES(24'd40), .TICK1_CYCLES(24'd20)) timer_counter_two_modes_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_input_pin(pin),
    .match_irq(match_irq), .irq(irq));
  pin_source pin_source_inst (.pclk(pclk), .presetn(presetn), .go(go), .pulses(pulses), .hi_len(hi_len),
    .lo_len(hi_len), .pin(pin), .busy(busy));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next transfer does not reassign psel in this time step
    @(posedge pclk);
  endtask

  function automatic logic [31:0] ctl(logic [2:0] src, logic [1:0] md, logic run, logic hv);
    ctl = (32'(src) << timer_pkg::SRC_LSB) | (32'(md) << timer_pkg::MODE_LSB)
        | (32'(run) << timer_pkg::RUN_BIT) | (32'(hv) << timer_pkg::HALVE_BIT);
  endfunction

  task automatic set_cmp(input logic [7:0] v);
    apb(1'b1, timer_pkg::OFF_CMP_LO, {24'h0, v});
    apb(1'b1, timer_pkg::OFF_CMP_HI, 32'h0);
  endtask

  task automatic wait_match(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (match_irq !== 1'b1 && n < 3000);
    check("match seen", 1, match_irq);
    @(posedge pclk);
  endtask

  // pulses on the pin, counting matches; with fall_only none may appear while the pin is high
  task automatic run_pulses(input logic [7:0] n, input logic [7:0] len, input logic fall_only, output int cnt);
    cnt = 0;
    pulses <= n;
    hi_len <= len;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(negedge pclk);
      if (match_irq === 1'b1) cnt++;
      if (match_irq === 1'b1 && pin === 1'b1 && fall_only) check("match while pin high", 0, 1);
    end while (busy === 1'b1);
    @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, timer_pkg::OFF_CTRL, 0);
    check("ctrl reset", 0, rd);
    check("mapped error", 0, err);
    apb(1'b0, timer_pkg::OFF_STATUS, 0);
    check("status reset", 0, rd);
    apb(1'b0, timer_pkg::OFF_MASK, 0);
    check("mask reset", 0, rd);
    apb(1'b1, timer_pkg::OFF_COUNT, 32'h1234);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("count read only", 0, rd);
    apb(1'b0, 8'h18, 0);
    check("unmapped data", 0, rd);
    check("unmapped error", 1, err);
    check("ready", 1, pready);
  endtask

  task automatic t_timer();
    logic [2:0] src[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
    logic hv[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int per[5] = '{80, 40, 320, 10, 20};
    set_cmp(8'h02);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, timer_pkg::OFF_CTRL, ctl(src[i], timer_pkg::MODE_TIMER, 1'b0, hv[i]));
      apb(1'b1, timer_pkg::OFF_CTRL, ctl(src[i], timer_pkg::MODE_TIMER, 1'b1, hv[i]));
      wait_match(p);
      @(negedge pclk);
      check("pulse width", 0, match_irq);
      wait_match(p);
      check("match period", per[i], p + 1);
      // stop before the next source is chosen
      apb(1'b1, timer_pkg::OFF_CTRL, ctl(src[i], timer_pkg::MODE_TIMER, 1'b0, hv[i]));
    end
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h4, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("count stopped", 0, rd);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h4, timer_pkg::MODE_TIMER, 1'b1, 1'b0));
    repeat (100) @(posedge pclk);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("reserved source", 0, rd);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h4, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_RSVD, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_RSVD, 1'b1, 1'b0));
    repeat (100) @(posedge pclk);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("reserved mode", 0, rd);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_RSVD, 1'b0, 1'b0));
  endtask

  task automatic t_inhibit();
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_TIMER, 1'b1, 1'b0));
    apb(1'b1, timer_pkg::OFF_CMP_LO, 32'h02);
    m = 0;
    repeat (100) begin
      @(negedge pclk);
      if (match_irq === 1'b1) m++;
    end
    @(posedge pclk);
    check("inhibited matches", 0, m);
    apb(1'b1, timer_pkg::OFF_CMP_HI, 32'h0);
    // the count ran past compare while inhibited, so restart it from zero
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_TIMER, 1'b1, 1'b0));
    wait_match(p);
    check("match resumes", 1, p < 80);
  endtask

  task automatic t_irq();
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b0, timer_pkg::OFF_STATUS, 0);
    check("status sticky", 1, rd);
    check("masked irq", 0, irq);
    apb(1'b1, timer_pkg::OFF_MASK, 32'h1);
    check("unmasked irq", 1, irq);
    apb(1'b1, timer_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, timer_pkg::OFF_STATUS, 0);
    check("status cleared", 0, rd);
    check("irq cleared", 0, irq);
    apb(1'b1, timer_pkg::OFF_MASK, 32'h0);
  endtask

  task automatic t_pin_modes();
    set_cmp(8'h02);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h0, timer_pkg::MODE_EVENT, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h0, timer_pkg::MODE_EVENT, 1'b1, 1'b0));
    run_pulses(8'd5, 8'd8, 1'b1, m);
    check("event matches", 2, m);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("event count", 1, rd);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(3'h0, timer_pkg::MODE_EVENT, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_PIN, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_PIN, timer_pkg::MODE_TIMER, 1'b1, 1'b0));
    // pin as clock in timer mode matches right after the counting edge, not at the fall
    run_pulses(8'd5, 8'd8, 1'b0, m);
    check("pin source matches", 2, m);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_PIN, timer_pkg::MODE_TIMER, 1'b0, 1'b0));
    set_cmp(8'h04);
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_WINDOW, 1'b0, 1'b0));
    apb(1'b1, timer_pkg::OFF_CTRL, ctl(timer_pkg::SRC_TAP3, timer_pkg::MODE_WINDOW, 1'b1, 1'b0));
    run_pulses(8'd1, 8'd42, 1'b0, m);
    check("window matches", 2, m);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    rd2 = rd;
    repeat (30) @(posedge pclk);
    apb(1'b0, timer_pkg::OFF_COUNT, 0);
    check("gate closed count", rd2, rd);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      $display("Error timeout expected 0 seen 1");
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    pulses = 8'h00;
    hi_len = 8'h08;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_timer();
    t_inhibit();
    t_irq();
    t_pin_modes();
    stop_test();
  end
endmodule
`default_nettype wire

// >>> tick_divider.sv
// prescaler that emits a one-cycle tick every period clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // control
  input  wire logic                          enable,
  input  wire logic [timer_pkg::DIV_W-1:0]   period,
  // output
  output logic                               tick
);
  logic [timer_pkg::DIV_W-1:0] cnt_reg;
  logic [timer_pkg::DIV_W-1:0] cnt_next;
  logic                        tick_next;
  logic                        tick_reg;

  always_comb begin
    cnt_next  = cnt_reg + 1'b1;
    tick_next = 1'b0;
    if (!enable) begin
      cnt_next = '0;
    end else if (cnt_reg >= period - 1'b1) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  // a dropped enable also kills a tick already in flight
  assign tick = tick_reg & enable;
endmodule
`default_nettype wire

// >>> timer_counter_two_modes.sv
// sixteen-bit up timer/counter with compare, three modes, apb registers
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module timer_counter_two_modes #(
  parameter logic [timer_pkg::DIV_W-1:0] TICK0_CYCLES = timer_pkg::DIV_W'(timer_pkg::TICK0_CYCLES),
  parameter logic [timer_pkg::DIV_W-1:0] TICK1_CYCLES = timer_pkg::DIV_W'(timer_pkg::TICK1_CYCLES)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external pin
  input  wire logic        count_input_pin,
  // interrupts
  output logic             match_irq,
  output logic             irq
);
  localparam logic [1:0] BLANK_LOAD = 2'(timer_pkg::BLANK_CYCLES);

  // register state
  logic [2:0]                  source_clock_select_reg, source_clock_select_next;
  timer_pkg::mode_e            mode_reg, mode_next;
  logic                        run_control_reg, run_control_next;
  logic                        prescale_halve_select_reg, prescale_halve_select_next;
  logic [timer_pkg::CNT_W-1:0] compare_value_reg, compare_value_next;
  logic                        cmp_inhibit_reg, cmp_inhibit_next;
  logic [1:0]                  blank_reg, blank_next;
  logic                        status_reg, status_next;
  logic                        mask_reg, mask_next;
  logic [31:0]                 prdata_reg, prdata_next;
  // counting state
  logic [timer_pkg::CNT_W-1:0] count_reg, count_next;
  logic                        pin_prev_reg;
  logic                        match_reg, match_next;
  // internal nets
  logic                        wr_access;
  logic                        rd_setup;
  logic                        addr_ok;
  logic                        wr_high;
  logic                        tick;
  logic                        tap_valid;
  logic [timer_pkg::DIV_W-1:0] tap_period;
  logic                        pin_rise;
  logic                        pin_fall;
  logic                        cmp_live;
  logic                        inc;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == timer_pkg::OFF_CTRL) || (a == timer_pkg::OFF_CMP_LO) ||
             (a == timer_pkg::OFF_CMP_HI) || (a == timer_pkg::OFF_COUNT) ||
             (a == timer_pkg::OFF_STATUS) || (a == timer_pkg::OFF_MASK);
  endfunction

  // apb: zero wait states, error on unmapped offsets
  assign wr_access = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign addr_ok   = mapped(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_ok;
  assign prdata    = prdata_reg;
  assign wr_high   = wr_access && paddr == timer_pkg::OFF_CMP_HI;

  // prescaler tap choice; reserved codes never tick
  always_comb begin
    tap_valid  = 1'b1;
    tap_period = timer_pkg::DIV_W'(timer_pkg::TICK3_CYCLES);
    case (source_clock_select_reg)
      timer_pkg::SRC_TAP0: tap_period = TICK0_CYCLES;
      timer_pkg::SRC_TAP1: tap_period = TICK1_CYCLES;
      timer_pkg::SRC_TAP2: tap_period = timer_pkg::DIV_W'(timer_pkg::TICK2_CYCLES);
      timer_pkg::SRC_TAP3: tap_period = timer_pkg::DIV_W'(timer_pkg::TICK3_CYCLES);
      default:             tap_valid  = 1'b0;
    endcase
    if (prescale_halve_select_reg) begin
      tap_period = tap_period << 1;
    end
  end

  tick_divider tick_divider_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (run_control_reg & tap_valid),
    .period  (tap_period),
    .tick    (tick)
  );

  // register file
  always_comb begin
    source_clock_select_next   = source_clock_select_reg;
    mode_next                  = mode_reg;
    run_control_next           = run_control_reg;
    prescale_halve_select_next = prescale_halve_select_reg;
    compare_value_next         = compare_value_reg;
    cmp_inhibit_next           = cmp_inhibit_reg;
    blank_next                 = (blank_reg != 2'h0) ? blank_reg - 2'h1 : 2'h0;
    status_next                = status_reg;
    mask_next                  = mask_reg;
    prdata_next                = prdata_reg;
    if (wr_access) begin
      case (paddr)
        timer_pkg::OFF_CTRL: begin
          // mode and source are expected to change only with run clear
          source_clock_select_next   = pwdata[timer_pkg::SRC_LSB +: 3];
          mode_next                  = timer_pkg::mode_e'(pwdata[timer_pkg::MODE_LSB +: 2]);
          run_control_next           = pwdata[timer_pkg::RUN_BIT];
          prescale_halve_select_next = pwdata[timer_pkg::HALVE_BIT];
        end
        timer_pkg::OFF_CMP_LO: begin
          compare_value_next[7:0] = pwdata[7:0];
          cmp_inhibit_next        = 1'b1;
        end
        timer_pkg::OFF_CMP_HI: begin
          compare_value_next[15:8] = pwdata[7:0];
          cmp_inhibit_next         = 1'b0;
          blank_next               = BLANK_LOAD;
        end
        timer_pkg::OFF_STATUS: status_next = status_reg & ~pwdata[0];
        timer_pkg::OFF_MASK:   mask_next   = pwdata[0];
        default: ;
      endcase
    end
    // a match in the clearing cycle still sets the flag
    if (match_next) begin
      status_next = 1'b1;
    end
    if (rd_setup) begin
      case (paddr)
        timer_pkg::OFF_CTRL:   prdata_next = {25'h0, prescale_halve_select_reg, run_control_reg,
                                              mode_reg, source_clock_select_reg};
        timer_pkg::OFF_CMP_LO: prdata_next = {24'h0, compare_value_reg[7:0]};
        timer_pkg::OFF_CMP_HI: prdata_next = {24'h0, compare_value_reg[15:8]};
        timer_pkg::OFF_COUNT:  prdata_next = {16'h0, count_reg};
        timer_pkg::OFF_STATUS: prdata_next = {31'h0, status_reg};
        timer_pkg::OFF_MASK:   prdata_next = {31'h0, mask_reg};
        default:               prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_clock_select_reg   <= timer_pkg::SRC_RST;
      mode_reg                  <= timer_pkg::MODE_TIMER;
      run_control_reg           <= 1'b0;
      prescale_halve_select_reg <= 1'b0;
      compare_value_reg         <= timer_pkg::CMP_RST;
      cmp_inhibit_reg           <= 1'b0;
      blank_reg                 <= 2'h0;
      status_reg                <= 1'b0;
      mask_reg                  <= timer_pkg::MASK_RST;
      prdata_reg                <= 32'h0;
    end else begin
      source_clock_select_reg   <= source_clock_select_next;
      mode_reg                  <= mode_next;
      run_control_reg           <= run_control_next;
      prescale_halve_select_reg <= prescale_halve_select_next;
      compare_value_reg         <= compare_value_next;
      cmp_inhibit_reg           <= cmp_inhibit_next;
      blank_reg                 <= blank_next;
      status_reg                <= status_next;
      mask_reg                  <= mask_next;
      prdata_reg                <= prdata_next;
    end
  end

  assign irq = status_reg & mask_reg;

  // counter core
  assign pin_rise = count_input_pin & ~pin_prev_reg;
  assign pin_fall = ~count_input_pin & pin_prev_reg;
  // timer and window compare every cycle, so the clear lands one cycle after the count reaches compare
  assign cmp_live = ~cmp_inhibit_reg && blank_reg == 2'h0 && count_reg == compare_value_reg;

  always_comb begin
    count_next = count_reg;
    match_next = 1'b0;
    inc        = 1'b0;
    case (mode_reg)
      timer_pkg::MODE_TIMER: begin
        // pin as clock in timer mode
        inc = (source_clock_select_reg == timer_pkg::SRC_PIN) ? pin_rise : tick;
        match_next = cmp_live;
      end
      timer_pkg::MODE_EVENT: begin
        inc        = pin_rise;
        match_next = cmp_live & pin_fall;
      end
      timer_pkg::MODE_WINDOW: begin
        // a gate edge near a tick can lose or gain one count
        inc        = tick & count_input_pin;
        match_next = cmp_live;
      end
      default: ;
    endcase
    if (!run_control_reg) begin
      match_next = 1'b0;
      count_next = '0;
    end else if (match_next) begin
      count_next = '0;
    end else if (inc) begin
      count_next = count_reg + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg    <= '0;
      pin_prev_reg <= 1'b0;
      match_reg    <= 1'b0;
    end else begin
      count_reg    <= count_next;
      pin_prev_reg <= count_input_pin;
      match_reg    <= match_next;
    end
  end

  assign match_irq = match_reg;

  // checks
  match_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq |-> count_reg == 16'h0 && $past(count_reg) == $past(compare_value_reg))
    else $error("match did not clear a counter equal to compare");
  single_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq && compare_value_reg != 16'h0 |=> !match_irq)
    else $error("match pulse longer than one cycle");
  stopped_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run_control_reg |=> count_reg == 16'h0 && !match_irq)
    else $error("counter not held at zero while stopped");
  event_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq && $past(mode_reg) == timer_pkg::MODE_EVENT |-> $past(pin_prev_reg) && !$past(count_input_pin))
    else $error("event match outside pin falling edge");
  event_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_EVENT && pin_rise |=> count_reg == $past(count_reg) + 16'h1)
    else $error("event edge not counted");
  window_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_WINDOW && !count_input_pin && !cmp_live |=> $stable(count_reg))
    else $error("window count moved with gate low");
  timer_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_TIMER && tick && !cmp_live |=> count_reg == $past(count_reg) + 16'h1)
    else $error("timer tick not counted");
  inhibit_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_inhibit_reg |=> !match_irq)
    else $error("match while compare inhibited");
  blank_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> ##1 !match_irq [*3])
    else $error("match inside blanking after high write");
  reserved_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == timer_pkg::MODE_TIMER && (source_clock_select_reg == 3'h4 || source_clock_select_reg == 3'h5)
    && !cmp_live && run_control_reg |=> $stable(count_reg))
    else $error("reserved source advanced the counter");
  status_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq |-> status_reg)
    else $error("match did not set status");
  rsvd_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_RSVD |=> $stable(count_reg))
    else $error("reserved mode moved the counter");
  window_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_WINDOW && tick && count_input_pin && !cmp_live
    |=> count_reg == $past(count_reg) + 16'h1)
    else $error("window tick not counted with gate high");
  event_no_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == timer_pkg::MODE_EVENT && !pin_fall |=> !match_irq)
    else $error("event match without pin falling edge");
  pin_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_control_reg && mode_reg == timer_pkg::MODE_TIMER && source_clock_select_reg == timer_pkg::SRC_PIN
    && pin_rise && !cmp_live |=> count_reg == $past(count_reg) + 16'h1)
    else $error("pin clock edge not counted");
  start_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(run_control_reg) |-> count_reg == 16'h0)
    else $error("counter did not start from zero");
  run_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq |-> $past(run_control_reg))
    else $error("match while stopped");
  status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == timer_pkg::OFF_STATUS && pwdata[0] && !match_next |=> !status_reg)
    else $error("status write one did not clear");
endmodule
`default_nettype wire

// >>> timer_pkg.sv
// shared constants for the sixteen-bit timer/counter with compare
package timer_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // tick periods per source code, as figures in ns
  localparam int unsigned TICK0_NS = 524_300_000;
  localparam int unsigned TICK1_NS = 512_000;
  localparam int unsigned TICK2_NS = 16_000;
  localparam int unsigned TICK3_NS = 500;
  localparam int unsigned TICK0_CYCLES = TICK0_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK1_CYCLES = TICK1_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK2_CYCLES = TICK2_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK3_CYCLES = TICK3_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 24;

  // compare blanking after a high-byte write, one machine cycle rounded up
  localparam int unsigned MACH_CYCLE_NS = 250;
  localparam int unsigned BLANK_CYCLES = (MACH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths
  localparam int unsigned CNT_W = 16;

  // apb byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CMP_LO  = 8'h04;
  localparam logic [7:0] OFF_CMP_HI  = 8'h08;
  localparam logic [7:0] OFF_COUNT   = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_MASK    = 8'h14;

  // control field positions
  localparam int unsigned SRC_LSB   = 0;
  localparam int unsigned MODE_LSB  = 3;
  localparam int unsigned RUN_BIT   = 5;
  localparam int unsigned HALVE_BIT = 6;

  // source codes
  localparam logic [2:0] SRC_TAP0  = 3'h0;
  localparam logic [2:0] SRC_TAP1  = 3'h1;
  localparam logic [2:0] SRC_TAP2  = 3'h2;
  localparam logic [2:0] SRC_TAP3  = 3'h3;
  localparam logic [2:0] SRC_PIN   = 3'h7;

  // reset values
  localparam logic [2:0]  SRC_RST   = 3'h0;
  localparam logic [15:0] CMP_RST   = 16'hffff;
  localparam logic [0:0]  MASK_RST  = 1'h0;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_EVENT,
    MODE_WINDOW,
    MODE_RSVD
  } mode_e;

endpackage
